/* src/erx_pkg.sv */
// Package: register map, field positions, reset values and shared types of the receive interrupt block
package erx_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] OFF_STATUS = 8'h00;   // mac_interrupt_status, read, write 1 to clear
    localparam logic [7:0] OFF_CLEAR = 8'h04;    // Write-only clear, same layout as status
    localparam logic [7:0] OFF_ENABLE = 8'h08;   // interrupt_enable_mask
    localparam logic [7:0] OFF_COMMAND = 8'h0C;  // mac_command_register
    localparam logic [7:0] OFF_LIMIT = 8'h10;    // rx_frame_length_limit
    localparam logic [7:0] OFF_START = 8'h14;    // receive_start_demand, write-only
    localparam logic [7:0] OFF_MISSED = 8'h18;   // missed_packet_counter, read clears
    localparam logic [7:0] OFF_DMA = 8'h1C;      // receive_dma_engine state, read-only

    // ==========================================================
    // Status and enable bit positions
    localparam int BIT_RX_INTR = 0;              // receive_interrupt summary
    localparam int BIT_TOO_LONG = 3;             // too_long_frame_flag
    localparam int BIT_GOOD = 4;                 // receive_good_flag
    localparam int BIT_ALIGN = 5;                // alignment_error_flag
    localparam int BIT_RUNT = 6;                 // runt_frame_flag
    localparam int BIT_MISSED_OVF = 7;           // missed_count_overflow_flag
    localparam int BIT_MAX_LEN = 8;              // max_length_exceeded_flag
    localparam int BIT_EARLY = 9;                // early_length_type_flag
    localparam int BIT_NO_DESC = 10;             // descriptor_unavailable_flag
    localparam int BIT_BUS_ERR = 11;             // rx_bus_error_flag
    localparam int BIT_CTRL = 14;                // control_frame_rx_flag
    localparam logic [31:0] FLAG_MASK = 32'h0000_4FF8;  // Flags this block owns
    localparam logic [31:0] IRQ_SRC_MASK = 32'h0000_7FFE; // Status bits 1..14 feed the interrupt

    // Command register fields
    localparam int CMD_ACCEPT_RUNT = 0;          // accept_runt_frames
    localparam int CMD_ACCEPT_LONG = 1;          // accept_long_frames
    localparam int CMD_FULL_DUPLEX = 2;          // Full duplex operation
    localparam logic [31:0] CMD_MASK = 32'h0000_0007;

    // ==========================================================
    // Reset values and frame sizes
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0800;
    localparam logic [15:0] MISSED_RESET = 16'h7FFF;
    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;  // 64 bytes
    localparam logic [15:0] MAX_FRAME_BYTES = 16'h05EE;  // 1518 bytes

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ERX_DMA_RUN = 2'b01,
        ERX_DMA_HALT = 2'b10
    } erx_dma_state_type;

    typedef struct packed {
        logic wr;                                // Write strobe
        logic rd;                                // Read strobe
        logic [7:0] addr;                        // Byte address
        logic [31:0] wdata;                      // Write data
    } erx_bus_req_type;

    typedef struct packed {
        logic frame_end;                         // Pulse: frame reception complete
        logic control_frame;                     // With frame_end: flow control frame
        logic odd_bits;                          // With frame_end: length not whole bytes
        logic [15:0] frame_length;               // With frame_end: length in bytes
        logic length_type_seen;                  // Pulse: Length/Type field received
        logic dma_error;                         // Pulse: ERROR response to a DMA access
        logic descriptor_request;                // Pulse: DMA wants a descriptor
        logic descriptor_available;              // With request: one is available
    } erx_rx_event_type;

endpackage : erx_pkg

/* src/erx_status.sv */
// Receive interrupt status, enable mask, frame checks, missed counter and receive DMA halt control
`timescale 1ns/1ps

module erx_status (
    input wire logic mclk,
    input wire logic reset,
    input wire erx_pkg::erx_bus_req_type bus_req,
    output logic [31:0] rd_data,
    input wire erx_pkg::erx_rx_event_type rx_event,
    output logic receive_interrupt,
    output logic frame_accept,
    output logic frame_drop,
    output logic dma_halted
);

    // ==========================================================
    // Register state
    logic [31:0] status_q;                       // Sticky flags
    logic [31:0] status_d;
    logic [31:0] enable_q;                       // interrupt_enable_mask
    logic [31:0] command_q;                      // mac_command_register
    logic [15:0] limit_q;                        // rx_frame_length_limit
    logic [15:0] missed_q;                       // missed_packet_counter
    logic [15:0] missed_d;
    logic [31:0] rd_data_q;                      // Read answer, one cycle after the strobe
    logic accept_q;                              // Good frame pulse
    logic drop_q;                                // Dropped frame pulse
    erx_pkg::erx_dma_state_type dma_q;           // receive_dma_engine state
    erx_pkg::erx_dma_state_type dma_d;

    // ==========================================================
    // Decoding
    logic wr_status;                             // W1C write to status or clear register
    logic wr_start;                              // Start demand write
    logic wr_missed;                             // Counter preload
    logic rd_missed;                             // Counter read, clears it
    logic [31:0] clear_mask;                     // Flags software clears this cycle
    logic [31:0] set_mask;                       // Flags hardware sets this cycle
    logic is_short;                              // Below 64 bytes
    logic is_long;                               // Above 1518 bytes
    logic over_limit;                            // Above programmed limit
    logic runt_fault;                            // Short and not accepted
    logic long_fault;                            // Long and not accepted
    logic frame_bad;                             // Frame is to be dropped
    logic starve;                                // Descriptor request with none available
    logic missed_wrap;                           // Counter steps past its top

    // Single address match helper, used for every write decode and the counter read
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_status = bus_req.wr && (hit(bus_req.addr, erx_pkg::OFF_STATUS) || hit(bus_req.addr, erx_pkg::OFF_CLEAR));
    assign wr_start = bus_req.wr && hit(bus_req.addr, erx_pkg::OFF_START);
    assign wr_missed = bus_req.wr && hit(bus_req.addr, erx_pkg::OFF_MISSED);
    assign rd_missed = bus_req.rd && hit(bus_req.addr, erx_pkg::OFF_MISSED);
    // Only ones written clear; zeros leave the flag as it is
    assign clear_mask = wr_status ? (bus_req.wdata & erx_pkg::FLAG_MASK) : 32'h0000_0000;

    // ==========================================================
    // Frame classification at the end of each frame
    assign is_short = rx_event.frame_length < erx_pkg::MIN_FRAME_BYTES;
    assign is_long = rx_event.frame_length > erx_pkg::MAX_FRAME_BYTES;
    assign over_limit = rx_event.frame_length > limit_q;
    // Accept bits remove the runt or long fault; the limit and odd bits still drop the frame
    assign runt_fault = is_short && !command_q[erx_pkg::CMD_ACCEPT_RUNT];
    assign long_fault = is_long && !command_q[erx_pkg::CMD_ACCEPT_LONG];
    // Alignment faults also drop: a frame with stray bits has no sound CRC
    assign frame_bad = runt_fault || long_fault || over_limit || rx_event.odd_bits;
    assign starve = rx_event.descriptor_request && !rx_event.descriptor_available;
    assign missed_wrap = rx_event.frame_end && frame_bad && (missed_q == 16'hFFFF);

    // Hardware set sources, one per flag
    always_comb begin
        set_mask = 32'h0000_0000;
        // Control frames mean nothing in half duplex, so they are ignored there
        set_mask[erx_pkg::BIT_CTRL] = rx_event.frame_end && rx_event.control_frame
            && command_q[erx_pkg::CMD_FULL_DUPLEX];
        set_mask[erx_pkg::BIT_BUS_ERR] = rx_event.dma_error;
        set_mask[erx_pkg::BIT_NO_DESC] = starve;
        set_mask[erx_pkg::BIT_EARLY] = rx_event.length_type_seen;
        set_mask[erx_pkg::BIT_MAX_LEN] = rx_event.frame_end && over_limit;
        set_mask[erx_pkg::BIT_MISSED_OVF] = missed_wrap;
        set_mask[erx_pkg::BIT_RUNT] = rx_event.frame_end && runt_fault;
        set_mask[erx_pkg::BIT_ALIGN] = rx_event.frame_end && rx_event.odd_bits;
        set_mask[erx_pkg::BIT_GOOD] = rx_event.frame_end && !frame_bad;
        set_mask[erx_pkg::BIT_TOO_LONG] = rx_event.frame_end && long_fault;
    end

    // A set in the same cycle as a clear wins, so no event is lost
    assign status_d = ((status_q & ~clear_mask) | set_mask) & erx_pkg::FLAG_MASK;

    // ==========================================================
    // Status flags
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_q <= erx_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Enable mask, command and limit registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            enable_q <= erx_pkg::ENABLE_RESET;
            command_q <= erx_pkg::COMMAND_RESET;
            limit_q <= erx_pkg::LIMIT_RESET;
        end else if (bus_req.wr) begin
            // Only interrupt source bits are kept in the mask
            if (hit(bus_req.addr, erx_pkg::OFF_ENABLE)) begin
                enable_q <= bus_req.wdata & erx_pkg::IRQ_SRC_MASK;
            end
            if (hit(bus_req.addr, erx_pkg::OFF_COMMAND)) begin
                command_q <= bus_req.wdata & erx_pkg::CMD_MASK;
            end
            if (hit(bus_req.addr, erx_pkg::OFF_LIMIT)) begin
                limit_q <= bus_req.wdata[15:0];
            end
        end
    end

    // ==========================================================
    // Missed packet counter: counts dropped frames, wraps to zero
    always_comb begin
        missed_d = missed_q;
        if (wr_missed) begin
            missed_d = bus_req.wdata[15:0];
        end else if (rd_missed) begin
            missed_d = 16'h0000;
        end
        // A drop during a read-clear still counts, so it is never lost
        if (rx_event.frame_end && frame_bad) begin
            missed_d = missed_d + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            missed_q <= erx_pkg::MISSED_RESET;
        end else begin
            missed_q <= missed_d;
        end
    end

    // ==========================================================
    // Receive DMA halt control
    always_comb begin
        dma_d = dma_q;
        unique case (dma_q)
            // Starving for descriptors parks the engine
            erx_pkg::ERX_DMA_RUN: begin
                if (starve) begin
                    dma_d = erx_pkg::ERX_DMA_HALT;
                end
            end
            // Only a start demand write releases it; a fresh starve keeps it parked
            erx_pkg::ERX_DMA_HALT: begin
                if (wr_start && !starve) begin
                    dma_d = erx_pkg::ERX_DMA_RUN;
                end
            end
            // Illegal codes park the engine until software restarts it
            default: begin
                dma_d = erx_pkg::ERX_DMA_HALT;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            dma_q <= erx_pkg::ERX_DMA_RUN;
        end else begin
            dma_q <= dma_d;
        end
    end

    // ==========================================================
    // Frame outcome pulses towards the receive path
    always_ff @(posedge mclk) begin
        if (reset) begin
            accept_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            accept_q <= rx_event.frame_end && !frame_bad;
            drop_q <= rx_event.frame_end && frame_bad;
        end
    end

    // ==========================================================
    // Read port: data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data_q <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                erx_pkg::OFF_STATUS: begin
                    rd_data_q <= status_q | {31'h0000_0000, receive_interrupt};
                end
                erx_pkg::OFF_ENABLE: begin
                    rd_data_q <= enable_q;
                end
                erx_pkg::OFF_COMMAND: begin
                    rd_data_q <= command_q;
                end
                erx_pkg::OFF_LIMIT: begin
                    rd_data_q <= {16'h0000, limit_q};
                end
                erx_pkg::OFF_MISSED: begin
                    rd_data_q <= {16'h0000, missed_q};
                end
                erx_pkg::OFF_DMA: begin
                    rd_data_q <= {31'h0000_0000, dma_q == erx_pkg::ERX_DMA_HALT};
                end
                // Write-only and unmapped addresses read as zero
                default: begin
                    rd_data_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rd_data_q <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Outputs
    // Level interrupt: falls as soon as every enabled flag is cleared
    assign receive_interrupt = |(status_q & enable_q & erx_pkg::IRQ_SRC_MASK);
    assign rd_data = rd_data_q;
    assign frame_accept = accept_q;
    assign frame_drop = drop_q;
    assign dma_halted = (dma_q == erx_pkg::ERX_DMA_HALT);

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Control frame in full duplex shows in the flag next cycle
    chk_ctrl_flag_set: assert property (
        rx_event.frame_end && rx_event.control_frame && command_q[erx_pkg::CMD_FULL_DUPLEX]
        |=> status_q[erx_pkg::BIT_CTRL])
        else $error("control frame flag not set");

    // An enabled control flag drives the interrupt
    chk_ctrl_irq_drive: assert property (
        status_q[erx_pkg::BIT_CTRL] && enable_q[erx_pkg::BIT_CTRL] |-> receive_interrupt)
        else $error("control flag did not raise interrupt");

    // Bus error flag set and interrupt one cycle later when enabled
    chk_bus_err_irq: assert property (
        rx_event.dma_error && enable_q[erx_pkg::BIT_BUS_ERR] && !(bus_req.wr && bus_req.addr == erx_pkg::OFF_ENABLE)
        |=> status_q[erx_pkg::BIT_BUS_ERR] && receive_interrupt)
        else $error("bus error not flagged");

    // Starved descriptor request halts the engine and sets the flag
    chk_halt_on_starve: assert property (
        starve |=> dma_halted && status_q[erx_pkg::BIT_NO_DESC])
        else $error("no halt on missing descriptor");

    // Halted engine stays halted until a start demand write
    chk_start_release: assert property (
        dma_halted && !wr_start |=> dma_halted)
        else $error("engine left halt without start demand");

    chk_start_resume: assert property (
        dma_halted && wr_start && !starve |=> !dma_halted)
        else $error("start demand did not resume engine");

    // Early notification flag follows the Length/Type event
    chk_early_flag: assert property (
        rx_event.length_type_seen |=> status_q[erx_pkg::BIT_EARLY])
        else $error("early flag not set");

    // Over the limit: dropped and flagged, never reported good
    chk_limit_drop: assert property (
        rx_event.frame_end && over_limit
        |=> frame_drop && !frame_accept && status_q[erx_pkg::BIT_MAX_LEN])
        else $error("over-limit frame not dropped");

    // Counter wrap sets the overflow flag and lands on zero
    chk_missed_wrap: assert property (
        missed_wrap && !wr_missed && !rd_missed
        |=> status_q[erx_pkg::BIT_MISSED_OVF] && missed_q == 16'h0000)
        else $error("missed counter overflow not flagged");

    // Short frame not accepted: drop and flag
    chk_runt_drop: assert property (
        rx_event.frame_end && is_short && !command_q[erx_pkg::CMD_ACCEPT_RUNT]
        |=> frame_drop && status_q[erx_pkg::BIT_RUNT])
        else $error("runt not dropped");

    // Accepted short frame leaves a clear runt flag clear
    chk_runt_accept: assert property (
        rx_event.frame_end && is_short && command_q[erx_pkg::CMD_ACCEPT_RUNT] && !status_q[erx_pkg::BIT_RUNT]
        |=> !status_q[erx_pkg::BIT_RUNT])
        else $error("accepted runt was flagged");

    // Odd bit count raises alignment flag
    chk_align_flag: assert property (
        rx_event.frame_end && rx_event.odd_bits |=> status_q[erx_pkg::BIT_ALIGN] && frame_drop)
        else $error("alignment error not flagged");

    // Clean frame within all bounds is reported good
    chk_good_frame: assert property (
        rx_event.frame_end && !frame_bad |=> frame_accept && status_q[erx_pkg::BIT_GOOD])
        else $error("good frame not reported");

    // Long frame not accepted: drop and flag
    chk_long_drop: assert property (
        rx_event.frame_end && is_long && !command_q[erx_pkg::CMD_ACCEPT_LONG]
        |=> frame_drop && status_q[erx_pkg::BIT_TOO_LONG])
        else $error("long frame not dropped");

    // Clearing every flag with no new event drops the interrupt next cycle
    chk_irq_quiet: assert property (
        wr_status && (bus_req.wdata & erx_pkg::FLAG_MASK) == erx_pkg::FLAG_MASK && set_mask == 32'h0000_0000
        |=> !receive_interrupt)
        else $error("interrupt stayed up after all flags cleared");

    // A set good flag survives any cycle without a one written to it
    chk_flag_sticky: assert property (
        status_q[erx_pkg::BIT_GOOD] && !(wr_status && bus_req.wdata[erx_pkg::BIT_GOOD])
        |=> $stable(status_q[erx_pkg::BIT_GOOD]))
        else $error("good flag dropped without clear");

endmodule : erx_status

/* test/erx_rx_model.sv */
// Receive path model: sends frames and event pulses toward the status block
`timescale 1ns/1ps

module erx_rx_model (
    input wire logic mclk,
    output erx_pkg::erx_rx_event_type ev
);
    // Idle fields churn each event so a stale length or qualifier never passes for a real one
    logic [22:0] junk = 23'h2A5C3;

    initial ev = '0;

    // ==========================================================
    // One event for exactly one cycle, then the pulses drop and the qualifiers go to junk
    task automatic send(input erx_pkg::erx_rx_event_type e);
        @(posedge mclk);
        ev <= e;
        @(posedge mclk);
        junk = {junk[21:0], junk[22] ^ junk[17]};
        ev <= junk & 23'h3FFFF1;
    endtask : send
endmodule : erx_rx_model

/* test/erx_status_bench.sv */
// Self-checking bench for the receive interrupt status block
`timescale 1ns/1ps
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin n_errors++; $display("wrong value at %0t: got %h want %h", $time, g, w); end end

module erx_status_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    erx_pkg::erx_bus_req_type bus_req = '0;
    erx_pkg::erx_rx_event_type ev;
    logic [31:0] rd_data, exp_st, en, r, got;
    logic irq, acc, drp, halted;
    logic rd_d = 1'b0;
    logic [31:0] q[$];
    integer seed = 32'h61FA;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Frame table: command, odd bits, control, dropped, length, flags expected
    logic [37:0] tab [10] = '{{3'h0, 3'h1, 16'd40, 16'h0040}, {3'h1, 3'h0, 16'd40, 16'h0010},
        {3'h0, 3'h1, 16'd1519, 16'h0008}, {3'h2, 3'h0, 16'd1519, 16'h0010},
        {3'h0, 3'h0, 16'd1518, 16'h0010}, {3'h0, 3'h0, 16'd64, 16'h0010},
        {3'h0, 3'h5, 16'd100, 16'h0020}, {3'h0, 3'h2, 16'd100, 16'h0010},
        {3'h4, 3'h2, 16'd100, 16'h4010}, {3'h2, 3'h1, 16'd1601, 16'h0100}};

    always #20 mclk = ~mclk;

    erx_rx_model m (.mclk(mclk), .ev(ev));

    erx_status uut (.mclk(mclk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .rx_event(ev),
        .receive_interrupt(irq), .frame_accept(acc), .frame_drop(drp), .dma_halted(halted));

    // ==========================================================
    // Watcher: the read answer stands one cycle only, so compare it mid-cycle against the oldest note
    always @(posedge mclk) begin
        rd_d <= bus_req.rd;
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    always @(negedge mclk) begin
        if (rd_d) begin
            got = q.pop_front();
            `CHK(rd_data, got)
        end
    end

    // ==========================================================
    // Bus tasks: one-cycle strobes launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        bus_req <= '0;
    endtask : rd

    // Status read with the summary bit worked out from the flags and the mask
    task automatic chk_st();
        logic i;
        i = |(exp_st & en & erx_pkg::IRQ_SRC_MASK);
        rd(erx_pkg::OFF_STATUS, exp_st | {31'h0, i});
        #1 `CHK(irq, i)
    endtask : chk_st

    task automatic frm(input logic [37:0] t);
        m.send('{frame_end: 1'b1, control_frame: t[33], odd_bits: t[34], frame_length: t[31:16], default: 1'b0});
        #1 `CHK({acc, drp}, {~t[32], t[32]})
        exp_st = exp_st | {16'h0, t[15:0]};
    endtask : frm

    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        exp_st = 0;
        en = 0;
        rd(erx_pkg::OFF_LIMIT, 32'h800);
        rd(erx_pkg::OFF_MISSED, 32'h7FFF);
        rd(erx_pkg::OFF_MISSED, 32'h0);
        rd(8'h20, 32'h0);
        wr(erx_pkg::OFF_LIMIT, 32'd1600);
        // Every frame case under a random mask; the clear alternates between both clear addresses
        for (int k = 0; k < 10; k++) begin
            r = $random(seed);
            en = r & erx_pkg::IRQ_SRC_MASK;
            wr(erx_pkg::OFF_ENABLE, r);
            rd(erx_pkg::OFF_ENABLE, en);
            wr(erx_pkg::OFF_COMMAND, {29'h0, tab[k][37:35]});
            frm(tab[k]);
            chk_st();
            rd(erx_pkg::OFF_MISSED, {31'h0, tab[k][32]});
            wr(k[0] ? erx_pkg::OFF_CLEAR : erx_pkg::OFF_STATUS, 32'h7FFE);
            exp_st = 0;
            chk_st();
        end
        en = erx_pkg::IRQ_SRC_MASK;
        wr(erx_pkg::OFF_ENABLE, en);
        m.send('{length_type_seen: 1'b1, default: 1'b0});
        m.send('{dma_error: 1'b1, default: 1'b0});
        m.send('{descriptor_request: 1'b1, descriptor_available: 1'b1, default: 1'b0});
        #1 `CHK(halted, 1'b0)
        m.send('{descriptor_request: 1'b1, default: 1'b0});
        #1 `CHK(halted, 1'b1)
        exp_st = 32'h0E00;
        chk_st();
        rd(erx_pkg::OFF_DMA, 32'h1);
        wr(erx_pkg::OFF_START, $random(seed));
        rd(erx_pkg::OFF_DMA, 32'h0);
        wr(erx_pkg::OFF_STATUS, 32'h0);
        chk_st();
        en = 32'h0800;
        wr(erx_pkg::OFF_ENABLE, en);
        chk_st();
        wr(erx_pkg::OFF_CLEAR, 32'h0800);
        exp_st = 32'h0600;
        chk_st();
        // Counter at its top: one dropped runt wraps it
        wr(erx_pkg::OFF_MISSED, 32'hFFFF);
        wr(erx_pkg::OFF_COMMAND, 32'h0);
        frm({3'h0, 3'h1, 16'd40, 16'h00C0});
        chk_st();
        rd(erx_pkg::OFF_MISSED, 32'h0);
        // One-cycle pulse on the reset input; flags and enable mask come back cleared
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        exp_st = 0;
        en = 0;
        chk_st();
        rd(erx_pkg::OFF_ENABLE, 32'h0);
        repeat (2) @(posedge mclk);
        conclude();
    end
endmodule : erx_status_bench
